// ==== design/cfm_pkg.sv ====
package cfm_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] ADDR_MAIN = 4'h0;
  localparam logic [3:0] ADDR_OFS_I = 4'h2;
  localparam logic [3:0] ADDR_RNG_I = 4'h3;
  localparam logic [3:0] ADDR_CAL_ADJ = 4'h4;
  localparam logic [3:0] ADDR_DES_ADJ = 4'h7;
  localparam logic [3:0] ADDR_OFS_Q = 4'hA;
  localparam logic [3:0] ADDR_RNG_Q = 4'hB;
  localparam logic [3:0] ADDR_PH_LO = 4'hC;
  localparam logic [3:0] ADDR_PH_HI = 4'hD;
  localparam logic [3:0] ADDR_SYNC = 4'hE;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int MAIN_TRIM_REQ = 15;
  localparam int MAIN_PHASE = 14;
  localparam int MAIN_SWING = 13;
  localparam int MAIN_TEST = 12;
  localparam int MAIN_PD_I = 11;
  localparam int MAIN_PD_Q = 10;
  localparam int MAIN_INTERLEAVE = 7;
  localparam int MAIN_Q_INPUT = 6;
  localparam int MAIN_I_TO_Q = 5;
  localparam int MAIN_TWOS = 4;
  localparam int MAIN_TSTAMP = 3;
  localparam int MAIN_SINGLE_RATE = 2;
  localparam int CAL_TRIM_RW = 15;
  localparam int PH_HI_ENABLE = 15;
  localparam int SYNC_SHARED_CLK = 6;
  localparam int SYNC_SLAVE = 3;
  localparam int SYNC_RC_ONE = 2;
  localparam int SYNC_RC_TWO = 1;
  localparam int SYNC_CLK_RST = 0;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [15:0] MAIN_RST = 16'h2000;
  localparam logic [15:0] OFS_RST = 16'h0000;
  localparam logic [15:0] RNG_MID = 16'h4000;
  localparam logic [15:0] RNG_MIN = 16'h0000;
  localparam logic [15:0] CAL_ADJ_RST = 16'h0000;
  localparam logic [15:0] DES_ADJ_RST = 16'h0040;
  localparam logic [15:0] PH_RST = 16'h0000;
  localparam logic [15:0] SYNC_RST = 16'h0000;

  // ---------------------------------------------------------------
  // serial frame: 8 command bits then 16 data bits, msb first
  // ---------------------------------------------------------------
  localparam int CMD_READ = 7;
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h18;

  // ---------------------------------------------------------------
  // synchronised pin vector positions
  // ---------------------------------------------------------------
  localparam int PIN_COUNT = 17;
  localparam int P_EXT = 0;
  localparam int P_INTERLEAVE = 1;
  localparam int P_DDR_PHASE = 2;
  localparam int P_TEST = 3;
  localparam int P_TRIM = 4;
  localparam int P_PD_I = 5;
  localparam int P_PD_Q = 6;
  localparam int P_RANGE = 7;
  localparam int P_COUPLING = 8;
  localparam int P_LOW_RATE = 9;
  localparam int P_DEMUX = 10;
  localparam int P_COMMON = 11;
  localparam int P_SCLK = 12;
  localparam int P_SEL_B = 13;
  localparam int P_SDI = 14;
  localparam int P_SPARE0 = 15;
  localparam int P_SPARE1 = 16;

endpackage

// ==== design/cfm_pin_sync.sv ====
`timescale 1ns/1ps

module cfm_pin_sync #(
  parameter int WIDTH = 17
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // pins and their synchronised copies
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } cfm_sync_s;

  cfm_sync_s state;
  cfm_sync_s next_state;

  // ---------------------------------------------------------------
  // two stages; only the second stage is read outside
  // ---------------------------------------------------------------
  always_comb begin
    next_state.first = pin_in;
    next_state.second = state.first;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pin_sync_out = state.second;

endmodule

// ==== design/cfm_serial_port.sv ====
`timescale 1ns/1ps

module cfm_serial_port (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // synchronised serial pins
  input wire logic sclk_in,
  input wire logic sel_b_in,
  input wire logic sdi_in,
  output logic sdo_out,
  // register side
  input wire logic enable_in,
  input wire logic [cfm_pkg::DATA_W-1:0] rdata_in,
  output logic [cfm_pkg::ADDR_W-1:0] addr_out,
  output logic [cfm_pkg::DATA_W-1:0] wdata_out,
  output logic wr_out
);
  import cfm_pkg::*;

  typedef struct packed {
    logic sclk_d;
    logic [4:0] cnt;
    logic [7:0] cmd;
    logic [15:0] shift;
    logic load;
    logic [15:0] rd;
    logic sdo;
    logic wr;
  } cfm_ser_s;

  cfm_ser_s state;
  cfm_ser_s next_state;
  logic rise;
  logic fall;

  assign rise = sclk_in & ~state.sclk_d;
  assign fall = ~sclk_in & state.sclk_d;

  // ---------------------------------------------------------------
  // frame engine: sample on rising sclk, launch read data on falling
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.sclk_d = sclk_in;
    next_state.wr = 1'b0;
    next_state.load = 1'b0;
    if (sel_b_in || !enable_in) begin
      // deselect aborts any partial frame, so no stray write
      next_state.cnt = 5'h00;
    end else if (rise && state.cnt != FRAME_BITS) begin
      next_state.cnt = state.cnt + 5'h01;
      if (state.cnt < CMD_BITS) begin
        next_state.cmd = {state.cmd[6:0], sdi_in};
        next_state.load = (state.cnt == CMD_BITS - 5'h01);
      end else begin
        next_state.shift = {state.shift[14:0], sdi_in};
        next_state.wr = (state.cnt == FRAME_BITS - 5'h01) &&
                        !state.cmd[CMD_READ];
      end
    end else if (fall && state.cnt > CMD_BITS &&
                 state.cnt < FRAME_BITS) begin
      next_state.rd = {state.rd[14:0], 1'b0};
      next_state.sdo = state.rd[14];
    end
    // address is settled one cycle before the read data is taken
    if (state.load) begin
      next_state.rd = rdata_in;
      next_state.sdo = rdata_in[15];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign addr_out = state.cmd[ADDR_W-1:0];
  assign wdata_out = state.shift;
  assign wr_out = state.wr;
  assign sdo_out = state.sdo;

endmodule

// ==== design/cfm_control_map.sv ====
`timescale 1ns/1ps

module cfm_control_map (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // control pins
  input wire logic extended_register_control_in,
  input wire logic interleave_pin_in,
  input wire logic double_rate_phase_pin_in,
  input wire logic test_pattern_pin_in,
  input wire logic on_command_trim_request_in,
  input wire logic power_down_i_pin_in,
  input wire logic power_down_q_pin_in,
  input wire logic input_range_setting_in,
  input wire logic coupling_select_pin_in,
  input wire logic low_rate_power_saving_in,
  input wire logic demux_bypass_pin_in,
  input wire logic output_common_level_pin_in,
  // serial control port
  input wire logic ser_clk_in,
  input wire logic ser_sel_b_in,
  input wire logic ser_data_in,
  output logic ser_data_out,
  // sampling mode
  output logic interleave_en_out,
  output logic q_input_interleave_out,
  output logic i_to_q_interleave_out,
  output logic both_input_clock_mode_out,
  // output data clock and format
  output logic clock_phase_select_out,
  output logic single_rate_data_out,
  output logic swing_high_out,
  output logic twos_complement_out,
  output logic test_pattern_en_out,
  output logic timestamp_en_out,
  // calibration and power
  output logic trim_start_out,
  output logic trim_readwrite_en_out,
  output logic power_down_i_out,
  output logic power_down_q_out,
  // analog adjust words
  output logic [cfm_pkg::DATA_W-1:0] offset_i_out,
  output logic [cfm_pkg::DATA_W-1:0] offset_q_out,
  output logic [cfm_pkg::DATA_W-1:0] range_i_out,
  output logic [cfm_pkg::DATA_W-1:0] range_q_out,
  output logic [cfm_pkg::DATA_W-1:0] calibration_adjust_out,
  output logic [cfm_pkg::DATA_W-1:0] interleave_timing_out,
  output logic clock_phase_adjust_en_out,
  output logic [cfm_pkg::DATA_W-1:0] clock_phase_low_out,
  output logic [cfm_pkg::DATA_W-1:0] clock_phase_high_out,
  // synchronisation and reference clocks
  output logic autosync_slave_out,
  output logic reference_clock_out_one_en_out,
  output logic reference_clock_out_two_en_out,
  output logic output_data_clock_reset_en_out,
  // pin-only features
  output logic coupling_select_out,
  output logic low_rate_power_saving_out,
  output logic demux_bypass_out,
  output logic output_common_level_out
);
  import cfm_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] ofs_i;
    logic [15:0] rng_i;
    logic [15:0] cal_adj;
    logic [15:0] des_adj;
    logic [15:0] ofs_q;
    logic [15:0] rng_q;
    logic [15:0] ph_lo;
    logic [15:0] ph_hi;
    logic [15:0] sync;
    logic trim_prev;
    logic [15:0] flags;
    logic [15:0] o_ofs_i;
    logic [15:0] o_ofs_q;
    logic [15:0] o_rng_i;
    logic [15:0] o_rng_q;
    logic [15:0] o_cal;
    logic [15:0] o_des;
    logic [15:0] o_ph_lo;
    logic [15:0] o_ph_hi;
    logic [3:0] o_sync;
  } cfm_map_s;

  cfm_map_s state;
  cfm_map_s next_state;
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin;
  logic ext;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic reg_wr;
  logic trim_level;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  assign pin_raw[P_EXT] = extended_register_control_in;
  assign pin_raw[P_INTERLEAVE] = interleave_pin_in;
  assign pin_raw[P_DDR_PHASE] = double_rate_phase_pin_in;
  assign pin_raw[P_TEST] = test_pattern_pin_in;
  assign pin_raw[P_TRIM] = on_command_trim_request_in;
  assign pin_raw[P_PD_I] = power_down_i_pin_in;
  assign pin_raw[P_PD_Q] = power_down_q_pin_in;
  assign pin_raw[P_RANGE] = input_range_setting_in;
  assign pin_raw[P_COUPLING] = coupling_select_pin_in;
  assign pin_raw[P_LOW_RATE] = low_rate_power_saving_in;
  assign pin_raw[P_DEMUX] = demux_bypass_pin_in;
  assign pin_raw[P_COMMON] = output_common_level_pin_in;
  assign pin_raw[P_SCLK] = ser_clk_in;
  assign pin_raw[P_SEL_B] = ser_sel_b_in;
  assign pin_raw[P_SDI] = ser_data_in;
  assign pin_raw[P_SPARE0] = 1'b0;
  assign pin_raw[P_SPARE1] = 1'b0;

  cfm_pin_sync #(
    .WIDTH(PIN_COUNT)
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .pin_in(pin_raw),
    .pin_sync_out(pin)
  );

  assign ext = pin[P_EXT];

  // ---------------------------------------------------------------
  // serial control port, live only in extended control
  // ---------------------------------------------------------------
  cfm_serial_port u_port (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .sclk_in(pin[P_SCLK]),
    .sel_b_in(pin[P_SEL_B]),
    .sdi_in(pin[P_SDI]),
    .sdo_out(ser_data_out),
    .enable_in(ext),
    .rdata_in(reg_rdata),
    .addr_out(reg_addr),
    .wdata_out(reg_wdata),
    .wr_out(reg_wr)
  );

  // ---------------------------------------------------------------
  // read mux; unmapped addresses read as zero
  // ---------------------------------------------------------------
  always_comb begin
    unique case (reg_addr)
      ADDR_MAIN: reg_rdata = state.cfg;
      ADDR_OFS_I: reg_rdata = state.ofs_i;
      ADDR_RNG_I: reg_rdata = state.rng_i;
      // trim values hidden unless access is enabled
      ADDR_CAL_ADJ: reg_rdata = state.cal_adj[CAL_TRIM_RW] ?
                                state.cal_adj : 16'h8000 & state.cal_adj;
      ADDR_DES_ADJ: reg_rdata = state.des_adj;
      ADDR_OFS_Q: reg_rdata = state.ofs_q;
      ADDR_RNG_Q: reg_rdata = state.rng_q;
      ADDR_PH_LO: reg_rdata = state.ph_lo;
      ADDR_PH_HI: reg_rdata = state.ph_hi;
      ADDR_SYNC: reg_rdata = state.sync;
      default: reg_rdata = 16'h0000;
    endcase
  end

  // trim request from the pin in any mode, from bit 15 only in ext mode
  assign trim_level = pin[P_TRIM] |
                      (ext & state.cfg[MAIN_TRIM_REQ]);

  // ---------------------------------------------------------------
  // register writes and effective feature settings
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_MAIN: next_state.cfg = reg_wdata;
        ADDR_OFS_I: next_state.ofs_i = reg_wdata;
        ADDR_RNG_I: next_state.rng_i = reg_wdata;
        ADDR_CAL_ADJ: begin
          // the enable bit is always writable; values only when enabled
          next_state.cal_adj[CAL_TRIM_RW] = reg_wdata[CAL_TRIM_RW];
          if (state.cal_adj[CAL_TRIM_RW]) begin
            next_state.cal_adj[14:0] = reg_wdata[14:0];
          end
        end
        ADDR_DES_ADJ: next_state.des_adj = reg_wdata;
        ADDR_OFS_Q: next_state.ofs_q = reg_wdata;
        ADDR_RNG_Q: next_state.rng_q = reg_wdata;
        ADDR_PH_LO: next_state.ph_lo = reg_wdata;
        ADDR_PH_HI: next_state.ph_hi = reg_wdata;
        ADDR_SYNC: next_state.sync = reg_wdata;
        default: next_state.cfg = state.cfg;
      endcase
    end
    next_state.trim_prev = trim_level;
    next_state.flags = '0;
    // pin-control mode: register contents have no effect
    next_state.flags[0] = ext ? state.cfg[MAIN_INTERLEAVE]
                              : pin[P_INTERLEAVE];
    next_state.flags[1] = ext & state.cfg[MAIN_Q_INPUT];
    next_state.flags[2] = ext & state.cfg[MAIN_I_TO_Q];
    next_state.flags[3] = ext & state.sync[SYNC_SHARED_CLK];
    next_state.flags[4] = ext ? state.cfg[MAIN_PHASE]
                              : pin[P_DDR_PHASE];
    next_state.flags[5] = ext & state.cfg[MAIN_SINGLE_RATE];
    next_state.flags[6] = ~ext | state.cfg[MAIN_SWING];
    next_state.flags[7] = ext & state.cfg[MAIN_TWOS];
    next_state.flags[8] = ext ? state.cfg[MAIN_TEST]
                              : pin[P_TEST];
    next_state.flags[9] = ext & state.cfg[MAIN_TSTAMP];
    // one-cycle start on each rising trim request
    next_state.flags[10] = trim_level & ~state.trim_prev;
    next_state.flags[11] = ext & state.cal_adj[CAL_TRIM_RW];
    next_state.flags[12] = pin[P_PD_I] |
                           (ext & state.cfg[MAIN_PD_I]);
    next_state.flags[13] = pin[P_PD_Q] |
                           (ext & state.cfg[MAIN_PD_Q]);
    next_state.flags[14] = ext & state.ph_hi[PH_HI_ENABLE];
    // pin-only features pass straight through
    next_state.flags[15] = pin[P_COUPLING];
    next_state.o_ofs_i = ext ? state.ofs_i : OFS_RST;
    next_state.o_ofs_q = ext ? state.ofs_q : OFS_RST;
    // pin high maps to the mid range, pin low to the minimum
    next_state.o_rng_i = ext ? state.rng_i :
                         (pin[P_RANGE] ? RNG_MID : RNG_MIN);
    next_state.o_rng_q = ext ? state.rng_q :
                         (pin[P_RANGE] ? RNG_MID : RNG_MIN);
    next_state.o_cal = ext ? state.cal_adj : CAL_ADJ_RST;
    next_state.o_des = ext ? state.des_adj : DES_ADJ_RST;
    next_state.o_ph_lo = ext ? state.ph_lo : PH_RST;
    next_state.o_ph_hi = ext ? state.ph_hi : PH_RST;
    next_state.o_sync = ext ? {state.sync[SYNC_SLAVE],
                               state.sync[SYNC_RC_ONE],
                               state.sync[SYNC_RC_TWO],
                               state.sync[SYNC_CLK_RST]}
                            : 4'h0;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      state <= '0;
      state.cfg <= MAIN_RST;
      state.ofs_i <= OFS_RST;
      state.rng_i <= RNG_MID;
      state.cal_adj <= CAL_ADJ_RST;
      state.des_adj <= DES_ADJ_RST;
      state.ofs_q <= OFS_RST;
      state.rng_q <= RNG_MID;
      state.ph_lo <= PH_RST;
      state.ph_hi <= PH_RST;
      state.sync <= SYNC_RST;
      state.flags <= 16'h0040; // swing high until first update
      state.o_ofs_i <= OFS_RST;
      state.o_ofs_q <= OFS_RST;
      state.o_rng_i <= RNG_MIN;
      state.o_rng_q <= RNG_MIN;
      state.o_cal <= CAL_ADJ_RST;
      state.o_des <= DES_ADJ_RST;
      state.o_ph_lo <= PH_RST;
      state.o_ph_hi <= PH_RST;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign interleave_en_out = state.flags[0];
  assign q_input_interleave_out = state.flags[1];
  assign i_to_q_interleave_out = state.flags[2];
  assign both_input_clock_mode_out = state.flags[3];
  assign clock_phase_select_out = state.flags[4];
  assign single_rate_data_out = state.flags[5];
  assign swing_high_out = state.flags[6];
  assign twos_complement_out = state.flags[7];
  assign test_pattern_en_out = state.flags[8];
  assign timestamp_en_out = state.flags[9];
  assign trim_start_out = state.flags[10];
  assign trim_readwrite_en_out = state.flags[11];
  assign power_down_i_out = state.flags[12];
  assign power_down_q_out = state.flags[13];
  assign clock_phase_adjust_en_out = state.flags[14];
  assign coupling_select_out = state.flags[15];
  assign offset_i_out = state.o_ofs_i;
  assign offset_q_out = state.o_ofs_q;
  assign range_i_out = state.o_rng_i;
  assign range_q_out = state.o_rng_q;
  assign calibration_adjust_out = state.o_cal;
  assign interleave_timing_out = state.o_des;
  assign clock_phase_low_out = state.o_ph_lo;
  assign clock_phase_high_out = state.o_ph_hi;
  assign autosync_slave_out = state.o_sync[3];
  assign reference_clock_out_one_en_out = state.o_sync[2];
  assign reference_clock_out_two_en_out = state.o_sync[1];
  assign output_data_clock_reset_en_out = state.o_sync[0];
  // the remaining pin-only settings come from the synchronisers
  assign low_rate_power_saving_out = pin[P_LOW_RATE];
  assign demux_bypass_out = pin[P_DEMUX];
  assign output_common_level_out = pin[P_COMMON];

endmodule

// ==== tb/cfm_control_map_monitor.sv ====
`timescale 1ns/1ps

// ------------------------------------------
// checker on the control map ports
// ------------------------------------------
module cfm_control_map_monitor (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // pins
  input wire logic extended_register_control_in,
  input wire logic interleave_pin_in,
  input wire logic double_rate_phase_pin_in,
  input wire logic test_pattern_pin_in,
  input wire logic power_down_i_pin_in,
  input wire logic power_down_q_pin_in,
  input wire logic input_range_setting_in,
  input wire logic low_rate_power_saving_in,
  input wire logic demux_bypass_pin_in,
  // outputs
  input wire logic interleave_en_out,
  input wire logic clock_phase_select_out,
  input wire logic swing_high_out,
  input wire logic twos_complement_out,
  input wire logic timestamp_en_out,
  input wire logic test_pattern_en_out,
  input wire logic trim_start_out,
  input wire logic power_down_i_out,
  input wire logic power_down_q_out,
  input wire logic [cfm_pkg::DATA_W-1:0] range_i_out,
  input wire logic low_rate_power_saving_out,
  input wire logic demux_bypass_out
);
  import cfm_pkg::*;
  wire pm = !extended_register_control_in;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // six samples cover the two-stage synchroniser plus the output flop
  chk_pin_swing_high: assert property (pm [*6] |-> swing_high_out)
    else $error("swing not high in pin mode");
  chk_pin_coding: assert property (pm [*6] |-> !twos_complement_out)
    else $error("twos complement in pin mode");
  chk_pin_stamp: assert property (pm [*6] |-> !timestamp_en_out)
    else $error("time stamp on in pin mode");
  chk_pin_interleave: assert property
    ((pm && $stable(interleave_pin_in)) [*6]
    |-> interleave_en_out == interleave_pin_in) else $error("interleave pin");
  chk_pin_phase: assert property
    ((pm && $stable(double_rate_phase_pin_in))
    [*6] |-> clock_phase_select_out == double_rate_phase_pin_in)
    else $error("phase does not follow pin");
  chk_pin_test: assert property
    ((pm && $stable(test_pattern_pin_in)) [*6]
    |-> test_pattern_en_out == test_pattern_pin_in) else $error("test pin");
  chk_pin_range: assert property
    ((pm && $stable(input_range_setting_in))
    [*6] |-> range_i_out == (input_range_setting_in ? RNG_MID : RNG_MIN))
    else $error("range does not follow pin");
  chk_pd_i_pin: assert property
    (power_down_i_pin_in [*6] |-> power_down_i_out)
    else $error("i power down pin ignored");
  chk_pd_q_pin: assert property
    (power_down_q_pin_in [*6] |-> power_down_q_out)
    else $error("q power down pin ignored");
  chk_trim_single: assert property (trim_start_out |=> !trim_start_out)
    else $error("trim start longer than one cycle");
  chk_pass_pins: assert property
    ($stable({low_rate_power_saving_in, demux_bypass_pin_in}) [*4] |->
    {low_rate_power_saving_out, demux_bypass_out} ==
    {low_rate_power_saving_in, demux_bypass_pin_in}) else $error("pass pins");
  cover property (trim_start_out);
  cover property (!pm && interleave_en_out);
  cover property (!pm && twos_complement_out);
endmodule

// ==== tb/cfm_host_model.sv ====
`timescale 1ns/1ps

// ------------------------------------------
// host side of the serial control port
// ------------------------------------------
module cfm_host_model (
  // clock
  input wire logic sys_clk_in,
  // serial port
  input wire logic sdo_in,
  output logic sclk_out,
  output logic sel_b_out,
  output logic sdi_out
);
  // idle: serial clock stopped low, select high
  initial begin
    sclk_out = 1'b0;
    sel_b_out = 1'b1;
    sdi_out = 1'b0;
  end
  // half periods of 5 cycles, two above the minimum the port needs
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [23:0] sh;
    sh = {cmd, wd};
    rd = 16'h0000;
    @(posedge sys_clk_in);
    #1 sel_b_out = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi_out = sh[i];
      repeat (5) @(posedge sys_clk_in);
      #1 sclk_out = 1'b1;
      rd = {rd[14:0], sdo_in};
      repeat (5) @(posedge sys_clk_in);
      #1 sclk_out = 1'b0;
    end
    repeat (5) @(posedge sys_clk_in);
    #1 sel_b_out = 1'b1;
    // released data line must not look like valid data
    sdi_out = ~sdi_out;
  endtask
endmodule

// ==== tb/tb_cfm_control_map.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end

// ------------------------------------------
// bench for the control map
// ------------------------------------------
module tb_cfm_control_map;
  import cfm_pkg::*;
  logic sys_clk_in, rst_b_in, extended_register_control_in;
  logic interleave_pin_in, double_rate_phase_pin_in, test_pattern_pin_in;
  logic on_command_trim_request_in, power_down_i_pin_in, power_down_q_pin_in;
  logic input_range_setting_in, coupling_select_pin_in;
  logic low_rate_power_saving_in, demux_bypass_pin_in;
  logic output_common_level_pin_in, ser_clk_in, ser_sel_b_in, ser_data_in;
  logic ser_data_out, interleave_en_out, q_input_interleave_out;
  logic i_to_q_interleave_out, both_input_clock_mode_out;
  logic clock_phase_select_out, single_rate_data_out, swing_high_out;
  logic twos_complement_out, test_pattern_en_out, timestamp_en_out;
  logic trim_start_out, trim_readwrite_en_out, power_down_i_out;
  logic power_down_q_out, clock_phase_adjust_en_out, autosync_slave_out;
  logic reference_clock_out_one_en_out, reference_clock_out_two_en_out;
  logic output_data_clock_reset_en_out, coupling_select_out;
  logic low_rate_power_saving_out, demux_bypass_out, output_common_level_out;
  logic [15:0] offset_i_out, offset_q_out, range_i_out, range_q_out;
  logic [15:0] calibration_adjust_out, interleave_timing_out, rd;
  logic [15:0] clock_phase_low_out, clock_phase_high_out;
  logic [11:0] pins;
  int n_fail, compares, n_trim;
  // pins as one vector: ext ctl, interleave, phase, test, trim, pd i, pd q,
  // range, coupling, low rate, demux, common level
  assign {extended_register_control_in, interleave_pin_in,
    double_rate_phase_pin_in, test_pattern_pin_in, on_command_trim_request_in,
    power_down_i_pin_in, power_down_q_pin_in, input_range_setting_in,
    coupling_select_pin_in, low_rate_power_saving_in, demux_bypass_pin_in,
    output_common_level_pin_in} = pins;
  // features of the main register: bits 7 to 5, then 14 to 10, then 4 to 2
  wire [10:0] feat = {interleave_en_out, q_input_interleave_out,
    i_to_q_interleave_out, clock_phase_select_out, swing_high_out,
    test_pattern_en_out, power_down_i_out, power_down_q_out,
    twos_complement_out, timestamp_en_out, single_rate_data_out};
  wire [4:0] sync_f = {both_input_clock_mode_out, autosync_slave_out,
    reference_clock_out_one_en_out, reference_clock_out_two_en_out,
    output_data_clock_reset_en_out};
  wire [3:0] pass_f = {coupling_select_out, low_rate_power_saving_out,
    demux_bypass_out, output_common_level_out};

  cfm_control_map u_cfm_control_map (.*);
  cfm_host_model u_cfm_host_model (.sys_clk_in, .sdo_in(ser_data_out),
    .sclk_out(ser_clk_in), .sel_b_out(ser_sel_b_in), .sdi_out(ser_data_in));

  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  // counts calibration starts
  always @(posedge sys_clk_in) if (trim_start_out === 1'b1) n_trim++;

  task automatic close_out;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // pins change after an edge; six cycles cover the synchroniser
  task automatic st(input logic [11:0] p);
    @(posedge sys_clk_in);
    #1 pins = p;
    repeat (6) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    u_cfm_host_model.xfer({4'h0, a}, d, rd);
    repeat (8) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    u_cfm_host_model.xfer({4'h8, a}, 16'h0000, rd);
    `CHK(rd, e)
  endtask

  initial begin
    repeat (30000) @(posedge sys_clk_in);
    n_fail++;
    close_out;
  end

  initial begin
    pins = 12'h000;
    n_fail = 0;
    compares = 0;
    n_trim = 0;
    rst_b_in = 1'b0;
    repeat (8) @(posedge sys_clk_in);
    #1 rst_b_in = 1'b1;
    st(12'h000);
    `CHK(sync_f, 5'h00)
    `CHK(feat, 11'h040)
    `CHK(range_q_out, RNG_MIN)
    `CHK(interleave_timing_out, DES_ADJ_RST)
    st(12'h7FF);
    `CHK(feat, 11'h4F8)
    `CHK(range_i_out, RNG_MID)
    `CHK(pass_f, 4'hF)
    `CHK(n_trim, 1)
    wr(ADDR_MAIN, 16'h0010);
    `CHK(feat, 11'h4F8)
    st(12'hF6F);
    `CHK(feat, 11'h058)
    `CHK(range_i_out, RNG_MID)
    rdc(ADDR_MAIN, MAIN_RST);
    st(12'h80F);
    wr(ADDR_MAIN, 16'h7CFC);
    `CHK(feat, 11'h7FF)
    rdc(ADDR_MAIN, 16'h7CFC);
    wr(ADDR_MAIN, 16'h0000);
    `CHK(feat, 11'h000)
    wr(ADDR_MAIN, 16'h8000);
    `CHK(n_trim, 2)
    wr(ADDR_SYNC, 16'h004F);
    `CHK(sync_f, 5'h1F)
    wr(ADDR_CAL_ADJ, 16'h0123);
    rdc(ADDR_CAL_ADJ, 16'h0000);
    wr(ADDR_CAL_ADJ, 16'h8000);
    wr(ADDR_CAL_ADJ, 16'h8123);
    rdc(ADDR_CAL_ADJ, 16'h8123);
    `CHK(trim_readwrite_en_out, 1'b1)
    `CHK(calibration_adjust_out, 16'h8123)
    wr(ADDR_OFS_I, 16'h0ABC);
    wr(ADDR_OFS_Q, 16'h1DEF);
    `CHK({offset_i_out, offset_q_out}, 32'h0ABC1DEF)
    wr(ADDR_PH_HI, 16'h8005);
    `CHK(clock_phase_adjust_en_out, 1'b1)
    wr(ADDR_PH_LO, 16'h0055);
    `CHK({clock_phase_low_out, clock_phase_high_out}, 32'h00558005)
    wr(ADDR_RNG_Q, 16'h1234);
    `CHK(range_q_out, 16'h1234)
    rdc(4'h1, 16'h0000);
    wr(ADDR_MAIN, 16'h0010);
    st(12'h000);
    `CHK(feat, 11'h040)
    `CHK(offset_i_out, OFS_RST)
    `CHK(range_q_out, RNG_MIN)
    close_out;
  end
endmodule

bind cfm_control_map cfm_control_map_monitor u_cfm_control_map_monitor (.*);
